/* hw/ewdt_map.vh */
// Purpose: constants for the watchdog control/status register and timing
// Assumes: 8-bit register port, 250 MHz system clock
// Notes: offsets are local choices
`ifndef EWDT_MAP_VH
`define EWDT_MAP_VH

`define EWDT_ADDR_W 2
`define EWDT_OFF_CTRL 2'h0
`define EWDT_OFF_CAUSE 2'h1
`define EWDT_OFF_COUNT 2'h2

`define EWDT_BIT_IRQ_FLAG 7
`define EWDT_BIT_IRQ_EN 6
`define EWDT_BIT_SEL3 5
`define EWDT_BIT_UNLOCK 4
`define EWDT_BIT_RST_EN 3
`define EWDT_BIT_CAUSE 3

`define EWDT_CTRL_RESET 8'h00
`define EWDT_SEL_MAX 4'h9
`define EWDT_BASE_SHIFT 11
`define EWDT_CNT_W 21
`define EWDT_UNLOCK_CYCLES 3'h4

`endif

/* hw/ewdt_sync.v */
// Purpose: two-flop synchroniser for a level from another domain
// Assumes: destination clock clk_i
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module ewdt_sync (
  input wire clk_i,
  input wire rst_i,
  input wire d_i,
  output wire q_o
);
  reg meta_ff;
  reg sync_ff;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule

/* hw/ewdt_tick.v */
// Purpose: turns the synchronised slow oscillator into one-cycle ticks
// Assumes: oscillator far slower than clk_i
// Notes: one tick per rising edge of the oscillator
`timescale 1ns/1ps
module ewdt_tick (
  input wire clk_i,
  input wire rst_i,
  input wire osc_sync_i,
  output reg tick_o
);
  reg last_ff;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_ff <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      last_ff <= osc_sync_i;
      tick_o <= osc_sync_i & ~last_ff;
    end
  end
endmodule

/* hw/ewdt_core.v */
// Purpose: enhanced watchdog timer with timed unlock and four modes
// Assumes: restart, vector-taken and global enable come from the core
// Notes: oscillator pin and fuse pass two flip-flops before use
// Function
// - count own oscillator, act at time-out
// - restart instruction clears the counter
// - interrupt on expiry, usable as wake
// - reset mode issues system reset request
// - combined mode: interrupt first, then reset
// - vector taken clears flag, and enable in combined mode
// - unserviced combined interrupt, next expiry resets
// - decode mode from fuse, enables
// - fuse forces reset enable one, irq zero
// - clear enable or change select needs unlock
// - unlock self-clears four cycles after set
// - flag bit 7 set on interrupt expiry
// - flag cleared by vector or writing one
// - interrupt needs global and local enable
// - cause flag forces reset enable on
// - four-bit select split bit 5, 2..0
// - codes 0..9 give 2048 to 1048576 cycles
// - reset pulse lasts one system clock
// - cause flag set on reset, write zero clears
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ewdt_map.vh"
module ewdt_core #(
  parameter CNT_W = `EWDT_CNT_W
) (
  input wire clk_i,
  input wire rst_i,
  input wire por_i,
  input wire wdt_osc_i,
  input wire always_on_fuse_i,
  input wire restart_i,
  input wire irq_taken_i,
  input wire global_irq_en_i,
  input wire [`EWDT_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  output wire irq_o,
  output reg sys_reset_o
);
  localparam MODE_STOP = 2'b00;
  localparam MODE_IRQ = 2'b01;
  localparam MODE_RST = 2'b10;
  localparam MODE_BOTH = 2'b11;

  wire osc_sync;
  wire fuse_sync;
  wire tick;

  reg irq_flag_ff;
  reg irq_en_ff;
  reg rst_en_ff;
  reg unlock_ff;
  reg [3:0] sel_ff;
  reg [2:0] unlock_cnt_ff;
  reg cause_ff;
  reg [CNT_W-1:0] cnt_ff;

  reg nxt_irq_flag;
  reg nxt_irq_en;
  reg nxt_rst_en;
  reg nxt_unlock;
  reg [3:0] nxt_sel;
  reg [2:0] nxt_unlock_cnt;
  reg nxt_cause;
  reg [CNT_W-1:0] nxt_cnt;

  reg [1:0] mode;
  reg [CNT_W-1:0] limit;
  wire eff_rst_en;
  wire eff_irq_en;
  wire expire;
  wire ctrl_wr;
  wire cause_wr;
  wire [3:0] wsel;

  wire sel_valid;

  ewdt_sync u_osc_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(wdt_osc_i),
    .q_o(osc_sync)
  );

  ewdt_sync u_fuse_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(always_on_fuse_i),
    .q_o(fuse_sync)
  );

  ewdt_tick u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .osc_sync_i(osc_sync),
    .tick_o(tick)
  );

  // effective enables seen by decode and read back
  // fuse forces enables
  assign eff_rst_en = rst_en_ff | cause_ff | fuse_sync;
  assign eff_irq_en = irq_en_ff & ~fuse_sync;

  // stopped when both effective enables are low
  // mode decode
  always @* begin
    mode = {eff_rst_en, eff_irq_en};
  end

  always @* begin
    limit = {CNT_W{1'b0}};
    if (sel_ff <= `EWDT_SEL_MAX) begin
      limit = ({{(CNT_W-1){1'b0}}, 1'b1} << (`EWDT_BASE_SHIFT + sel_ff))
              - {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      limit = {CNT_W{1'b1}};
    end
  end

  // reserved select codes never expire
  assign sel_valid = (sel_ff <= `EWDT_SEL_MAX);
  // one expiry per slow tick at the limit
  assign expire = tick &
                  (cnt_ff == limit) &
                  sel_valid &
                  (mode != MODE_STOP);
  // register strobes decoded per offset
  assign ctrl_wr = wr_i & (addr_i == `EWDT_OFF_CTRL);
  assign cause_wr = wr_i & (addr_i == `EWDT_OFF_CAUSE);
  // select field split across bit 5 and bits 2..0
  assign wsel = {wdata_i[`EWDT_BIT_SEL3], wdata_i[2:0]};

  always @* begin
    nxt_irq_flag = irq_flag_ff;
    nxt_irq_en = irq_en_ff;
    nxt_rst_en = rst_en_ff;
    nxt_unlock = unlock_ff;
    nxt_sel = sel_ff;
    nxt_unlock_cnt = unlock_cnt_ff;
    nxt_cause = cause_ff;
    nxt_cnt = cnt_ff;

    // stopped mode holds the counter at zero
    // restart clears counter
    if (restart_i || mode == MODE_STOP || expire) begin
      nxt_cnt = {CNT_W{1'b0}};
    end else if (tick) begin
      nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end

    // a write with unlock low ends the window early
    // unlock self clear
    if (unlock_ff) begin
      if (unlock_cnt_ff == `EWDT_UNLOCK_CYCLES - 3'h1) begin
        nxt_unlock = 1'b0;
        nxt_unlock_cnt = 3'h0;
      end else begin
        nxt_unlock_cnt = unlock_cnt_ff + 3'h1;
      end
    end

    if (ctrl_wr) begin
      nxt_irq_en = wdata_i[`EWDT_BIT_IRQ_EN];
      if (wdata_i[`EWDT_BIT_IRQ_FLAG]) begin
        nxt_irq_flag = 1'b0;
      end
      // each set restarts the four-cycle window
      if (wdata_i[`EWDT_BIT_UNLOCK]) begin
        nxt_unlock = 1'b1;
        nxt_unlock_cnt = 3'h0;
      end else begin
        nxt_unlock = 1'b0;
      end
      if (unlock_ff) begin
        nxt_rst_en = wdata_i[`EWDT_BIT_RST_EN];
        nxt_sel = wsel;
      end else if (wdata_i[`EWDT_BIT_RST_EN]) begin
        nxt_rst_en = 1'b1;
      end
    end

    // irq enable dropped only in combined mode
    // vector clears enable, flag
    if (irq_taken_i) begin
      nxt_irq_flag = 1'b0;
      if (mode == MODE_BOTH) begin
        nxt_irq_en = 1'b0;
      end
    end

    if (cause_wr && !wdata_i[`EWDT_BIT_CAUSE]) begin
      nxt_cause = 1'b0;
    end

    if (expire) begin
      case (mode)
        MODE_IRQ: begin
          nxt_irq_flag = 1'b1;
        end
        MODE_BOTH: begin
          if (!irq_flag_ff) begin
            nxt_irq_flag = 1'b1;
          end
        end
        default: begin
          nxt_irq_flag = nxt_irq_flag;
        end
      endcase
    end

    if (sys_reset_o) begin
      nxt_cause = 1'b1;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_flag_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      rst_en_ff <= 1'b0;
      unlock_ff <= 1'b0;
      sel_ff <= 4'h0;
      unlock_cnt_ff <= 3'h0;
      cnt_ff <= {CNT_W{1'b0}};
      sys_reset_o <= 1'b0;
    end else begin
      irq_flag_ff <= nxt_irq_flag;
      irq_en_ff <= nxt_irq_en;
      rst_en_ff <= nxt_rst_en;
      unlock_ff <= nxt_unlock;
      sel_ff <= nxt_sel;
      unlock_cnt_ff <= nxt_unlock_cnt;
      cnt_ff <= nxt_cnt;
      // expire is tick-gated, so the request lasts one clock
      // reset mode request
      sys_reset_o <= expire & ((mode == MODE_RST) |
                     ((mode == MODE_BOTH) & irq_flag_ff));
    end
  end

  // cause flag survives system reset, cleared by power-on or by writing zero
  always @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      cause_ff <= 1'b0;
    end else begin
      cause_ff <= nxt_cause;
    end
  end

  assign irq_o = irq_flag_ff & eff_irq_en & global_irq_en_i;

  // read data stand one cycle, zero otherwise
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `EWDT_OFF_CTRL: begin
          rdata_o <= {irq_flag_ff, eff_irq_en, sel_ff[3], unlock_ff,
                      eff_rst_en, sel_ff[2:0]};
        end
        `EWDT_OFF_CAUSE: begin
          rdata_o <= {4'h0, cause_ff, 3'h0};
        end
        `EWDT_OFF_COUNT: begin
          rdata_o <= cnt_ff[CNT_W-1:CNT_W-8];
        end
        default: begin
          rdata_o <= 8'h00;
        end
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

/* tb/ewdt_assertions.sv */
// Purpose: port checks for the watchdog core
// Assumes: registered read data, synced fuse
// Notes: bound after the module
`timescale 1ns/1ps
`include "ewdt_map.vh"
module ewdt_chk (
  input wire clk_i,
  input wire rst_i,
  input wire always_on_fuse_i,
  input wire irq_taken_i,
  input wire global_irq_en_i,
  input wire [`EWDT_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire irq_o,
  input wire sys_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_pls;
    sys_reset_o |=> !sys_reset_o;
  endproperty
  a_pls: assert property (p_pls) else $error("reset pulse too long");
  property p_gl;
    irq_o |-> global_irq_en_i;
  endproperty
  a_gl: assert property (p_gl) else $error("irq without global");
  property p_fz;
    always_on_fuse_i [*4] ##0 (rd_i && addr_i == 0) |=> rdata_o[3] && !rdata_o[6];
  endproperty
  a_fz: assert property (p_fz) else $error("fuse not forcing");
  property p_fi;
    always_on_fuse_i [*4] |-> !irq_o;
  endproperty
  a_fi: assert property (p_fi) else $error("irq under fuse");
  sequence s_ul;
    wr_i && addr_i == 0 && wdata_i[4:3] == 2'b11;
  endsequence
  property p_ul1;
    s_ul ##1 !wr_i [*3] ##1 (rd_i && addr_i == 0) |=> rdata_o[4];
  endproperty
  a_ul1: assert property (p_ul1) else $error("unlock dropped early");
  property p_ul0;
    s_ul ##1 !wr_i [*5] ##1 (rd_i && addr_i == 0) |=> !rdata_o[4];
  endproperty
  a_ul0: assert property (p_ul0) else $error("unlock stuck");
  property p_vec;
    irq_taken_i |-> ##[1:2] !irq_o;
  endproperty
  a_vec: assert property (p_vec) else $error("vector left irq");
  property p_cs;
    (rd_i && addr_i == 1) ##1 rdata_o[3] ##1 (rd_i && addr_i == 0)
      |=> rdata_o[3];
  endproperty
  a_cs: assert property (p_cs) else $error("cause not forcing");
endmodule
bind ewdt_core ewdt_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .always_on_fuse_i(always_on_fuse_i), .irq_taken_i(irq_taken_i),
  .global_irq_en_i(global_irq_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .sys_reset_o(sys_reset_o));

/* tb/ewdt_cpu_model.sv */
// Purpose: core side that takes the watchdog vector
// Assumes: vector runs four cycles after the request
// Notes: serve_i low leaves the request pending
`timescale 1ns/1ps
module ewdt_cpu_model (
  input wire clk_i,
  input wire irq_i,
  input wire serve_i,
  output reg taken_o
);
  reg [1:0] dly_ff;
  initial begin
    taken_o = 1'b0;
    dly_ff = 2'h0;
  end
  always @(posedge clk_i) begin
    taken_o <= serve_i && irq_i && !taken_o && dly_ff == 2'h3;
    dly_ff <= (serve_i && irq_i && !taken_o) ? dly_ff + 2'h1 : 2'h0;
  end
endmodule

/* tb/enhanced_watchdog_timer_tb_top.sv */
// Purpose: self-checking bench for the watchdog core
// Assumes: oscillator sped up, expiry at select 0 near 8500 clocks
// Notes: serve gates the core model
`timescale 1ns/1ps
module enhanced_watchdog_timer_tb_top;
  reg clk_i, rst_i, por_i, osc, fuse, restart_i, gie, wr_i, rd_i, serve;
  reg [1:0] addr_i;
  reg [7:0] wdata_i;
  wire [7:0] rdata_o;
  wire irq_o, sys_reset_o, taken;
  integer err_count, compares, resets;
  ewdt_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .wdt_osc_i(osc), .always_on_fuse_i(fuse), .restart_i(restart_i),
    .irq_taken_i(taken), .global_irq_en_i(gie), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .sys_reset_o(sys_reset_o));
  ewdt_cpu_model cpu_u (.clk_i(clk_i), .irq_i(irq_o), .serve_i(serve),
    .taken_o(taken));
  initial begin
    clk_i = 0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    osc = 0;
    forever #8.3 osc = ~osc;
  end
  always @(posedge clk_i) if (sys_reset_o === 1'b1) resets <= resets + 1;
  task chk(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task wr(input [1:0] a, input [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task rd(input [1:0] a, input [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1 chk(rdata_o, exp);
  endtask
  task wirq;
    repeat (9200) if (irq_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    chk({7'h00, irq_o}, 8'h01);
  endtask
  task wrst(input integer n);
    repeat (9200) if (resets < n) begin
      @(posedge clk_i);
      #1;
    end
    chk(resets[7:0], n[7:0]);
  endtask
  task t_reg;
    rd(0, 8'h00);
    rd(1, 8'h00);
    rd(3, 8'h00);
    rd(2, 8'h00);
    wr(0, 8'h0F);
    rd(0, 8'h08);
    wr(0, 8'h00);
    rd(0, 8'h08);
    wr(0, 8'h18);
    cyc(2);
    rd(0, 8'h18);
    rd(0, 8'h08);
    restart_i <= 1;
    @(posedge clk_i);
    restart_i <= 0;
    wr(0, 8'h18);
    wr(0, 8'h01);
    rd(0, 8'h01);
    wr(0, 8'h19);
    wr(0, 8'h00);
    rd(0, 8'h00);
    $display("register test done");
  endtask
  task t_irq;
    wr(0, 8'h40);
    cyc(9200);
    chk({7'h00, irq_o}, 8'h00);
    rd(0, 8'hC0);
    gie <= 1;
    @(posedge clk_i);
    #1 chk({7'h00, irq_o}, 8'h01);
    wr(0, 8'hC0);
    rd(0, 8'h40);
    serve <= 1;
    wirq;
    cyc(8);
    rd(0, 8'h40);
    chk(resets[7:0], 8'h00);
    $display("interrupt test done");
  endtask
  task t_comb;
    wr(0, 8'h48);
    wirq;
    cyc(8);
    rd(0, 8'h08);
    serve <= 0;
    wr(0, 8'h48);
    wirq;
    wrst(1);
    rd(1, 8'h08);
    rd(0, 8'hC8);
    wr(1, 8'h00);
    rd(1, 8'h00);
    wr(0, 8'h98);
    wr(0, 8'h00);
    rd(0, 8'h00);
    $display("combined test done");
  endtask
  task t_rst;
    wr(0, 8'h08);
    repeat (3) begin
      cyc(6000);
      restart_i <= 1;
      @(posedge clk_i);
      restart_i <= 0;
    end
    chk(resets[7:0], 8'h01);
    wrst(2);
    wr(1, 8'h00);
    wr(0, 8'h18);
    wr(0, 8'h00);
    rd(0, 8'h00);
    fuse <= 1;
    cyc(4);
    rd(0, 8'h08);
    wr(0, 8'h40);
    rd(0, 8'h08);
    $display("reset and fuse test done");
  endtask
  task report_and_stop;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    err_count = err_count + 1;
    report_and_stop;
  end
  initial begin
    {rst_i, por_i, fuse, restart_i, gie, wr_i, rd_i, serve} = 8'h C0;
    addr_i = 2'h0;
    wdata_i = 8'h00;
    err_count = 0;
    compares = 0;
    resets = 0;
    cyc(5);
    rst_i <= 0;
    por_i <= 0;
    t_reg;
    t_irq;
    t_comb;
    t_rst;
    report_and_stop;
  end
endmodule
